// File: logic/dtc_cfg.svh
// Register map, field positions and reset values of the dual timer/counter block
// Behaviour
// - Two independent timer/counters, each with a 16-bit counter.
// - Timer one input picked from pin lines four to seven by selector.
// - Timer one output can drive pin line zero.
// - Timer two input is pin line four; output drives pin line one.
// - Each timer has load register, counter and readable latch, 16 bits.
// - Load and latch are reached one byte per bus access.
// - No pin reserved; pin line zero free unless timer one drives it.
// - Clock and enable come from pins or scaled system clocks.
// - Clock rate of one timer is independent of the other.
// - Pin clocking acts on rising, falling or both edges.
// - Output pins still read back their true pin level.
// - Output value can be set before the pin is driven.
// - Pull-ups on lines four to seven and eleven only when requested.
// - Pull-ups stay off during init and self-test.
// - Lines zero to seven latch a low level until read.
// - Timing figures hold at the rated clock within ten percent.
// - Every pin input passes a synchroniser on the system clock.
// - Measurements complete in hardware regardless of reads.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define DTC_OFS_CTRL      8'h00
`define DTC_OFS_PIN_DIR   8'h04
`define DTC_OFS_PIN_OUT   8'h08
`define DTC_OFS_PIN_IN    8'h0c
`define DTC_OFS_LOWDET    8'h10
`define DTC_BANK_COM      3'h0
`define DTC_BANK_TC1      3'h1
`define DTC_BANK_TC2      3'h2
`define DTC_TOFS_CFG      5'h00
`define DTC_TOFS_LOAD_LO  5'h04
`define DTC_TOFS_LOAD_HI  5'h08
`define DTC_TOFS_LATCH_LO 5'h0c
`define DTC_TOFS_LATCH_HI 5'h10

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define DTC_CTRL_PULLUP   0
`define DTC_CTRL_INIT_OK  1
`define DTC_CFG_PRE_LO    0
`define DTC_CFG_PRE_HI    2
`define DTC_CFG_CLK_EXT   3
`define DTC_CFG_EDGE_LO   4
`define DTC_CFG_EDGE_HI   5
`define DTC_CFG_EN_PIN    6
`define DTC_CFG_OUT_EN    7
`define DTC_CFG_SEL_LO    8
`define DTC_CFG_SEL_HI    9
`define DTC_CFG_RUN       10
`define DTC_EDGE_RISE     2'h1
`define DTC_EDGE_FALL     2'h2
`define DTC_EDGE_BOTH     2'h3
`define DTC_PULL_MASK     12'h8f0
`define DTC_LOWDET_MASK   12'h0ff
`define DTC_PIN_TC_IN     4
`define DTC_PIN_TC1_OUT   0
`define DTC_PIN_TC2_OUT   1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DTC_RST_CTRL      2'h0
`define DTC_RST_PINS      12'h000
`define DTC_RST_LEVEL     12'hfff
`define DTC_RST_TOUT      2'h0
`define DTC_RST_WORD      16'h0000
`define DTC_RST_BYTE      8'h00
`define DTC_RST_DIV       16'h0000
`define DTC_CNT_TOP       16'hffff
`define DTC_RST_DATA      32'h0000_0000

`endif

// File: logic/dtc_pkg.sv
// Types shared by the dual timer/counter block
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_BUS_IDLE = 2'b01,
        DTC_BUS_DONE = 2'b10
    } dtc_bus_state_type;

    typedef logic [15:0] dtc_word_type;
    typedef logic [11:0] dtc_pins_type;

endpackage : dtc_pkg

// File: logic/dtc_top.sv
// Dual 16-bit timer/counter with pin sync, pull-ups and low-level latches
`timescale 1ns/10ps
`include "dtc_cfg.svh"

module dtc_top
    import dtc_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [11:0] i_pin_line,
    output logic      [11:0] o_pin_line_out,
    output logic      [11:0] o_pin_line_oe,
    output logic      [11:0] o_pullup_en
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Tick of the shared divider; each timer taps its own rate
    function automatic logic tick_of(input dtc_word_type d, input logic [2:0] e);
        dtc_word_type m;
        m = (16'h0002 << e) - 16'h0001;
        return (d & m) == m;
    endfunction : tick_of

    function automatic logic edge_hit(input logic c, input logic p, input logic [1:0] s);
        logic rise;
        logic fall;
        rise = c & ~p;
        fall = ~c & p;
        case (s)
            `DTC_EDGE_RISE: return rise;
            `DTC_EDGE_FALL: return fall;
            `DTC_EDGE_BOTH: return rise | fall;
            default:        return 1'b0;
        endcase
    endfunction : edge_hit

    function automatic dtc_pins_type wr12(input dtc_pins_type o, input logic [31:0] d,
                                          input logic [3:0] be);
        dtc_pins_type r;
        r = o;
        if (be[0]) begin
            r[7:0] = d[7:0];
        end
        if (be[1]) begin
            r[11:8] = d[11:8];
        end
        return r;
    endfunction : wr12

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    dtc_pins_type s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
    dtc_pins_type lvl_nxt;

    always_comb begin
        lvl_nxt = lvl_r;
        for (int i = 0; i < 12; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                lvl_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            // Idle-high start, so reset itself leaves no false low or edge
            s1_r    <= `DTC_RST_LEVEL;
            s2_r    <= `DTC_RST_LEVEL;
            s3_r    <= `DTC_RST_LEVEL;
            lvl_r   <= `DTC_RST_LEVEL;
            lvl_d_r <= `DTC_RST_LEVEL;
        end else begin
            s1_r    <= i_pin_line;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            lvl_r   <= lvl_nxt;
            lvl_d_r <= lvl_r;
        end
    end

    // ----------------------------------------------------------------
    // Bus, registers and timers
    // ----------------------------------------------------------------
    dtc_bus_state_type state_r, state_nxt;
    logic              wait_r, wait_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [1:0]        ctrl_r, ctrl_nxt;
    dtc_pins_type      dir_r, dir_nxt, pout_r, pout_nxt, ld_r, ld_nxt;
    dtc_pins_type      out_r, out_nxt, oe_r, oe_nxt, pull_r, pull_nxt;
    dtc_word_type      div_r, div_nxt;
    dtc_word_type      cfg_r   [2];
    dtc_word_type      cfg_nxt [2];
    dtc_word_type      load_r  [2];
    dtc_word_type      load_nxt[2];
    dtc_word_type      cnt_r   [2];
    dtc_word_type      cnt_nxt [2];
    dtc_word_type      lat_r   [2];
    dtc_word_type      lat_nxt [2];
    logic [7:0]        stg_r   [2];
    logic [7:0]        stg_nxt [2];
    logic [7:0]        hold_r  [2];
    logic [7:0]        hold_nxt[2];
    logic [1:0]        tout_r, tout_nxt;

    logic       req, acc, wr_go, rd_acc;
    logic [2:0] bank;
    logic [4:0] tofs;
    logic       tin, tprev, step, evt;
    int         tsel;

    always_comb begin
        req    = i_avs_read | i_avs_write;
        acc    = req && (state_r == DTC_BUS_IDLE);
        wr_go  = i_avs_write && (state_r == DTC_BUS_DONE);
        rd_acc = acc && i_avs_read;
        bank   = i_avs_address[7:5];
        tofs   = i_avs_address[4:0];

        state_nxt = acc ? DTC_BUS_DONE : DTC_BUS_IDLE;
        wait_nxt  = !acc;
        rdata_nxt = rdata_r;
        ctrl_nxt  = ctrl_r;
        dir_nxt   = dir_r;
        pout_nxt  = pout_r;
        div_nxt   = div_r + 16'h0001;
        tout_nxt  = tout_r;
        ld_nxt    = ld_r | (~lvl_r & `DTC_LOWDET_MASK);

        // Read data is formed when the request is taken
        if (rd_acc) begin
            rdata_nxt = `DTC_RST_DATA;
            if (bank == `DTC_BANK_COM) begin
                case (i_avs_address)
                    `DTC_OFS_CTRL:    rdata_nxt[1:0]  = ctrl_r;
                    `DTC_OFS_PIN_DIR: rdata_nxt[11:0] = dir_r;
                    `DTC_OFS_PIN_OUT: rdata_nxt[11:0] = pout_r;
                    `DTC_OFS_PIN_IN:  rdata_nxt[11:0] = lvl_r;
                    `DTC_OFS_LOWDET: begin
                        rdata_nxt[11:0] = ld_r;
                        // Only bits shown are cleared, so a new low is not lost
                        ld_nxt = (ld_r & ~ld_r) | (~lvl_r & `DTC_LOWDET_MASK);
                    end
                    default: rdata_nxt = `DTC_RST_DATA;
                endcase
            end
        end

        if (wr_go && bank == `DTC_BANK_COM) begin
            case (i_avs_address)
                `DTC_OFS_CTRL:    ctrl_nxt = i_avs_byteenable[0] ? i_avs_writedata[1:0] : ctrl_r;
                `DTC_OFS_PIN_DIR: dir_nxt  = wr12(dir_r, i_avs_writedata, i_avs_byteenable);
                // Written while undriven sets the first driven level
                `DTC_OFS_PIN_OUT: pout_nxt = wr12(pout_r, i_avs_writedata, i_avs_byteenable);
                default: ;
            endcase
        end

        for (int t = 0; t < 2; t++) begin
            cfg_nxt[t]  = cfg_r[t];
            load_nxt[t] = load_r[t];
            cnt_nxt[t]  = cnt_r[t];
            lat_nxt[t]  = lat_r[t];
            stg_nxt[t]  = stg_r[t];
            hold_nxt[t] = hold_r[t];

            // Timer one follows the selector, timer two is fixed
            tsel  = (t == 0) ? `DTC_PIN_TC_IN + int'(cfg_r[t][`DTC_CFG_SEL_HI:`DTC_CFG_SEL_LO])
                             : `DTC_PIN_TC_IN;
            tin   = lvl_r[tsel];
            tprev = lvl_d_r[tsel];
            // Pin clock with edge choice, else own scaled system clock
            step  = cfg_r[t][`DTC_CFG_CLK_EXT]
                  ? edge_hit(tin, tprev, cfg_r[t][`DTC_CFG_EDGE_HI:`DTC_CFG_EDGE_LO])
                  : tick_of(div_r, cfg_r[t][`DTC_CFG_PRE_HI:`DTC_CFG_PRE_LO]);
            evt   = cfg_r[t][`DTC_CFG_CLK_EXT]
                  ? tick_of(div_r, cfg_r[t][`DTC_CFG_PRE_HI:`DTC_CFG_PRE_LO])
                  : edge_hit(tin, tprev, cfg_r[t][`DTC_CFG_EDGE_HI:`DTC_CFG_EDGE_LO]);
            if (cfg_r[t][`DTC_CFG_EN_PIN] && !tin) begin
                step = 1'b0;
            end

            if (cfg_r[t][`DTC_CFG_RUN]) begin
                if (evt) begin
                    lat_nxt[t] = cnt_r[t];
                    cnt_nxt[t] = load_r[t];
                end else if (step) begin
                    if (cnt_r[t] == `DTC_CNT_TOP) begin
                        cnt_nxt[t]  = load_r[t];
                        tout_nxt[t] = ~tout_r[t];
                    end else begin
                        cnt_nxt[t] = cnt_r[t] + 16'h0001;
                    end
                end
            end

            if (bank == ((t == 0) ? `DTC_BANK_TC1 : `DTC_BANK_TC2)) begin
                if (rd_acc) begin
                    case (tofs)
                        `DTC_TOFS_CFG:     rdata_nxt[15:0] = cfg_r[t];
                        `DTC_TOFS_LOAD_LO: rdata_nxt[7:0]  = load_r[t][7:0];
                        `DTC_TOFS_LOAD_HI: rdata_nxt[7:0]  = load_r[t][15:8];
                        `DTC_TOFS_LATCH_LO: begin
                            rdata_nxt[7:0] = lat_r[t][7:0];
                            hold_nxt[t]    = lat_r[t][15:8];
                        end
                        `DTC_TOFS_LATCH_HI: rdata_nxt[7:0] = hold_r[t];
                        default: ;
                    endcase
                end
                if (wr_go) begin
                    case (tofs)
                        `DTC_TOFS_CFG: begin
                            if (i_avs_byteenable[0]) begin
                                cfg_nxt[t][7:0] = i_avs_writedata[7:0];
                            end
                            if (i_avs_byteenable[1]) begin
                                cfg_nxt[t][15:8] = i_avs_writedata[15:8];
                            end
                        end
                        // Low byte waits so the counter never sees half a value
                        `DTC_TOFS_LOAD_LO: stg_nxt[t] = i_avs_writedata[7:0];
                        `DTC_TOFS_LOAD_HI: load_nxt[t] = {i_avs_writedata[7:0], stg_r[t]};
                        default: ;
                    endcase
                end
            end
        end

        // Timer outputs claim their pin only when enabled
        out_nxt = pout_r;
        oe_nxt  = dir_r;
        if (cfg_r[0][`DTC_CFG_OUT_EN]) begin
            out_nxt[`DTC_PIN_TC1_OUT] = tout_r[0];
            oe_nxt[`DTC_PIN_TC1_OUT]  = 1'b1;
        end
        if (cfg_r[1][`DTC_CFG_OUT_EN]) begin
            out_nxt[`DTC_PIN_TC2_OUT] = tout_r[1];
            oe_nxt[`DTC_PIN_TC2_OUT]  = 1'b1;
        end

        // Held off until software marks init and self-test done
        pull_nxt = (ctrl_r[`DTC_CTRL_PULLUP] && ctrl_r[`DTC_CTRL_INIT_OK])
                 ? `DTC_PULL_MASK : `DTC_RST_PINS;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= DTC_BUS_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= `DTC_RST_DATA;
            ctrl_r  <= `DTC_RST_CTRL;
            dir_r   <= `DTC_RST_PINS;
            pout_r  <= `DTC_RST_PINS;
            ld_r    <= `DTC_RST_PINS;
            out_r   <= `DTC_RST_PINS;
            oe_r    <= `DTC_RST_PINS;
            pull_r  <= `DTC_RST_PINS;
            div_r   <= `DTC_RST_DIV;
            tout_r  <= `DTC_RST_TOUT;
            for (int t = 0; t < 2; t++) begin
                cfg_r[t]  <= `DTC_RST_WORD;
                load_r[t] <= `DTC_RST_WORD;
                cnt_r[t]  <= `DTC_RST_WORD;
                lat_r[t]  <= `DTC_RST_WORD;
                stg_r[t]  <= `DTC_RST_BYTE;
                hold_r[t] <= `DTC_RST_BYTE;
            end
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r  <= ctrl_nxt;
            dir_r   <= dir_nxt;
            pout_r  <= pout_nxt;
            ld_r    <= ld_nxt;
            out_r   <= out_nxt;
            oe_r    <= oe_nxt;
            pull_r  <= pull_nxt;
            div_r   <= div_nxt;
            tout_r  <= tout_nxt;
            for (int t = 0; t < 2; t++) begin
                cfg_r[t]  <= cfg_nxt[t];
                load_r[t] <= load_nxt[t];
                cnt_r[t]  <= cnt_nxt[t];
                lat_r[t]  <= lat_nxt[t];
                stg_r[t]  <= stg_nxt[t];
                hold_r[t] <= hold_nxt[t];
            end
        end
    end

    assign o_avs_readdata    = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_pin_line_out    = out_r;
    assign o_pin_line_oe     = oe_r;
    assign o_pullup_en       = pull_r;

endmodule : dtc_top

// File: bench/dtc_pin_model.sv
// Far-side pin hardware model for the dual timer/counter block
`timescale 1ns/10ps
module dtc_pin_model (
    input  wire logic        i_clk_sys,
    input  wire logic [11:0] i_pin_line_out,
    input  wire logic [11:0] i_pin_line_oe,
    input  wire logic [11:0] i_pullup_en,
    input  wire logic [11:0] i_ext_en,
    input  wire logic [11:0] i_ext_val,
    output logic      [11:0] o_pin_line
);
    // ------------------------------------------------------------
    // Line levels
    // ------------------------------------------------------------
    // Floating lines flip each cycle so no stale level looks valid
    logic [11:0] float_r = 12'h000;
    always @(posedge i_clk_sys) float_r <= ~float_r;
    always_comb begin
        for (int b = 0; b < 12; b++) begin
            if (i_pin_line_oe[b]) o_pin_line[b] = i_pin_line_out[b];
            else if (i_ext_en[b]) o_pin_line[b] = i_ext_val[b];
            else if (i_pullup_en[b]) o_pin_line[b] = 1'b1;
            else o_pin_line[b] = float_r[b];
        end
    end
endmodule : dtc_pin_model

// File: bench/dtc_top_chk.sv
// Port checker for the dual timer/counter block
`timescale 1ns/10ps
module dtc_top_chk (
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [11:0] o_pin_line_out,
    input wire logic [11:0] o_pin_line_oe,
    input wire logic [11:0] o_pullup_en
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low twice");
    property p_taken;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_taken: assert property (p_taken) else $error("no answer");
    property p_cause; $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_pull_mask; (o_pullup_en & 12'h70f) == 12'h000; endproperty
    a_pull_mask: assert property (p_pull_mask) else $error("pull-up on wrong line");
    property p_rst;
        $fell(i_reset) |-> o_avs_waitrequest && o_pullup_en == 12'h000
            && o_pin_line_oe == 12'h000 && o_avs_readdata == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_rd_hold; !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_oe_cause;
        !$past(i_reset) && $changed(o_pin_line_oe) |-> $past(i_avs_write) || $past(i_avs_write, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
    property p_out_cause;
        !$past(i_reset) && $changed(o_pin_line_out[11:2])
            |-> $past(i_avs_write) || $past(i_avs_write, 2);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("output moved alone");
    property p_pull_cause;
        !$past(i_reset) && $changed(o_pullup_en) |-> $past(i_avs_write) || $past(i_avs_write, 2);
    endproperty
    a_pull_cause: assert property (p_pull_cause) else $error("pull-up moved alone");
endmodule : dtc_top_chk
bind dtc_top dtc_top_chk i_dtc_top_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_pin_line_out(o_pin_line_out),
    .o_pin_line_oe(o_pin_line_oe), .o_pullup_en(o_pullup_en));

// File: bench/dual_timer_counter_io_pins_test.sv
// Testbench for the dual timer/counter block
`timescale 1ns/10ps
module dual_timer_counter_io_pins_test
    import dtc_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   adr = 8'h00;
    logic         rd = 1'b0;
    logic         wr = 1'b0;
    logic [31:0]  wdat = 32'h0;
    logic [31:0]  rdat, q;
    logic         waitr;
    logic [15:0]  w;
    logic [15:0]  ofs [4] = '{16'h0, 16'h1f, 16'h17, 16'h3};
    dtc_pins_type pin, pout, poe, pull, sv;
    dtc_pins_type ext_en = 12'hfff;
    dtc_pins_type ext_val = 12'hfff;
    int           mismatches = 0;
    int           tests_run = 0;
    dtc_top i_dtc_top (.i_clk_sys(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'h3),
        .o_avs_readdata(rdat), .o_avs_waitrequest(waitr), .i_pin_line(pin),
        .o_pin_line_out(pout), .o_pin_line_oe(poe), .o_pullup_en(pull));
    dtc_pin_model i_dtc_pin_model (.i_clk_sys(clk), .i_pin_line_out(pout),
        .i_pin_line_oe(poe), .i_pullup_en(pull), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_pin_line(pin));
    initial forever #5 clk = ~clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("Compares %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Capture and tick may land on one edge, so one count of slack
    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo);
        tests_run++;
        if (got !== lo && got !== lo + 16'h0001) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, lo);
        end
    endtask : chk_rng
    task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        rd <= r;
        wr <= !r;
        do begin
            @(posedge clk);
            n++;
        end while (waitr !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            mismatches++;
            summarize();
        end
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        chk(q, e);
    endtask : rchk
    task automatic rword(input logic [7:0] b);
        bus(1'b1, b + 8'h0c, 32'h0);
        w[7:0] = q[7:0];
        bus(1'b1, b + 8'h10, 32'h0);
        w[15:8] = q[7:0];
    endtask : rword
    task automatic wload(input logic [7:0] b, input logic [15:0] v);
        bus(1'b0, b + 8'h04, {24'h0, v[7:0]});
        bus(1'b0, b + 8'h08, {24'h0, v[15:8]});
    endtask : wload
    task automatic lvl(input int b, input logic v, input int n);
        ext_val <= (ext_val & ~(12'h001 << b)) | (12'(v) << b);
        repeat (n) @(posedge clk);
    endtask : lvl
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(8'h00, 32'h0);
        rchk(8'h14, 32'h0);
        rchk(8'h10, 32'h0);
        ext_val <= 12'ha5c;
        bus(1'b0, 8'h08, 32'h1);
        bus(1'b0, 8'h04, 32'h3);
        repeat (8) @(posedge clk);
        rchk(8'h0c, 32'ha5d);
        ext_en <= 12'h000;
        bus(1'b0, 8'h00, 32'h1);
        repeat (2) @(posedge clk);
        chk({20'h0, pull}, 32'h0);
        bus(1'b0, 8'h00, 32'h3);
        repeat (8) @(posedge clk);
        chk({20'h0, pull}, 32'h8f0);
        bus(1'b1, 8'h0c, 32'h0);
        chk(q & 32'h8f0, 32'h8f0);
        ext_en <= 12'hfff;
        ext_val <= 12'hfff;
        bus(1'b0, 8'h04, 32'h0);
        repeat (8) @(posedge clk);
        bus(1'b1, 8'h10, 32'h0);
        rchk(8'h10, 32'h0);
        lvl(2, 1'b0, 6);
        lvl(2, 1'b1, 12);
        rchk(8'h10, 32'h4);
        rchk(8'h10, 32'h0);
        wload(8'h40, 16'h12fa);
        bus(1'b0, 8'h40, 32'h0410);
        lvl(4, 1'b0, 10);
        lvl(4, 1'b1, 20);
        lvl(4, 1'b0, 20);
        lvl(4, 1'b1, 20);
        bus(1'b1, 8'h4c, 32'h0);
        w[7:0] = q[7:0];
        lvl(4, 1'b0, 4);
        lvl(4, 1'b1, 4);
        lvl(4, 1'b0, 4);
        lvl(4, 1'b1, 20);
        bus(1'b1, 8'h50, 32'h0);
        w[15:8] = q[7:0];
        chk_rng(w, 16'h130d);
        rword(8'h40);
        chk_rng(w, 16'h12fd);
        for (int m = 1; m < 4; m++) begin
            bus(1'b0, 8'h40, 32'h0400 | (m << 4));
            lvl(4, 1'b0, 20);
            lvl(4, 1'b1, 24);
            lvl(4, 1'b0, 40);
            lvl(4, 1'b1, 8);
            lvl(4, 1'b0, 30);
            rword(8'h40);
            chk_rng(w, 16'h12fa + ofs[m]);
        end
        wload(8'h20, 16'h0050);
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, 8'h20, 32'h0411 | (k << 8));
            lvl(4 + k, 1'b0, 10);
            lvl(4 + k, 1'b1, 20);
            lvl(4 + k, 1'b0, 20 + 8 * k);
            lvl(4 + k, 1'b1, 20);
            rword(8'h20);
            chk_rng(w, 16'h0059 + 16'(2 * k));
        end
        chk({20'h0, poe}, 32'h0);
        wload(8'h20, 16'hfff0);
        wload(8'h40, 16'hfff0);
        // Counters reload only on an event or at the top count, so one rising edge seeds both
        bus(1'b0, 8'h20, 32'h0491);
        bus(1'b0, 8'h40, 32'h0490);
        lvl(4, 1'b0, 10);
        lvl(4, 1'b1, 100);
        chk({30'h0, poe[1:0]}, 32'h3);
        sv = pout;
        repeat (32) @(posedge clk);
        chk({31'h0, pout[1]}, {31'h0, ~sv[1]});
        repeat (32) @(posedge clk);
        chk({30'h0, pout[1:0]}, {30'h0, sv[1], ~sv[0]});
        summarize();
    end
endmodule : dual_timer_counter_io_pins_test
